// [hdl/pol_seq.v]
// supervisory sequencer: enable, soft start/stop, tracking, ready output,
// current fault handling, sync role and interleave phase of a two-phase regulator.
// assumes measurement codes and pins synchronous to core_clk; AXI4-Lite host.
// Contract
// - ready low during ramp and faults
// - ready rises above configurable on-threshold
// - ready drops below under-voltage limit
// - configurable delay before ready rises
// - ready open-drain, push-pull selectable
// - current faults armed after ramp-up
// - latch-off holds until clear or re-enable
// - hiccup retries after fixed interval
// - hiccup default, no delayed shutdown
// - current sharing forces latch-off
// - reverse current fault, same responses
// - two phases give twice switching rate
// - sync pin input, output or ignored
// - pwm edge offset by order over group
// - four-bit fields, group zero means sixteen
// - group zero, order from bus address
// - on delay then rise ramp
// - soft stop: off delay then fall
// - soft stop off by default
// - no rectifier sinking outside regulation
// - tracking follows input until target
// - tracking ignores soft-start/stop timing
// - enable polarity selectable
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "pol_seq_regs.vh"
`default_nettype none
module pol_seq #(
  parameter W = 16,
  parameter HICCUP_CYCLES = `HICCUP_CYC
) (
  input wire core_clk,
  input wire srst,
  input wire ce,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire enablePin,
  input wire [6:0] busAddress,
  input wire [W-1:0] voutCode,
  input wire signed [W-1:0] ioutCode,
  input wire [W-1:0] trackingInputPin,
  input wire syncPinIn,
  output reg syncPinOut,
  output reg syncPinOeN,
  output reg outputReadyPinOut,
  output reg outputReadyPinOeN,
  output reg regulateEn,
  output reg syncRectEn,
  output reg [W-1:0] vSetpoint,
  output reg pwmEdgeA,
  output reg pwmEdgeB
);
  localparam S_OFF = 7'h01;
  localparam S_ONDLY = 7'h02;
  localparam S_RISE = 7'h04;
  localparam S_ON = 7'h08;
  localparam S_OFFDLY = 7'h10;
  localparam S_FALL = 7'h20;
  localparam S_FAULT = 7'h40;

  function [W-1:0] mergeBytes;
    input [W-1:0] old;
    input [31:0] data;
    input [3:0] strb;
    reg [31:0] t;
    integer i;
    begin
      t = {{(32-W){1'b0}}, old};
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          t[8*i +: 8] = data[8*i +: 8];
        end
      end
      mergeBytes = t[W-1:0];
    end
  endfunction

  function mapped;
    input [5:0] a;
    begin
      mapped = (a <= `A_STATUS) && (a[1:0] == 2'h0);
    end
  endfunction

  reg [9:0] ctrl_reg;
  reg [W-1:0] vTarget_reg, pgOn_reg, uvLimit_reg, pgDelay_reg;
  reg [W-1:0] tonDelay_reg, tonRise_reg, toffDelay_reg, toffFall_reg;
  reg [W-1:0] ocLimit_reg, rcLimit_reg, period_reg;
  reg [3:0] order_reg, group_reg;
  reg orderLoaded_reg;
  reg [6:0] state_reg;
  reg [31:0] tmr_reg;
  reg [W-1:0] acc_reg;
  reg [W-1:0] pgCnt_reg;
  reg [3:0] ocCnt_reg, rcCnt_reg;
  reg ocFlag_reg, rcFlag_reg, latched_reg;
  reg pg_reg;
  reg [W-1:0] phCnt_reg;
  reg syncPrev_reg;
  reg [W-1:0] offset_reg;
  reg awHeld_reg, wHeld_reg;
  reg [5:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = (awHeld_reg || awTake) && (wHeld_reg || wTake) && !s_axi_bvalid;
  wire [5:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr[5:0];
  wire [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  wire wrCtrl = doWrite && wrAddr == `A_CTRL;
  wire [W-1:0] ctrlNew = mergeBytes({{(W-10){1'b0}}, ctrl_reg}, wrData, wrStrb);
  wire clearCmd = wrCtrl && ctrlNew[`F_CLRFLT];
  wire [1:0] syncRole = ctrl_reg[`F_SYNCHI:`F_SYNCLO];
  wire trackMode = ctrl_reg[`F_TRACK];
  wire enActive = ctrl_reg[`F_ENPOL] ? enablePin : !enablePin;
  // sharing rails cannot hiccup, so latch-off is forced there
  wire ocLatch = ctrl_reg[`F_OCLATCH] || ctrl_reg[`F_SHARE];
  wire rcLatch = ctrl_reg[`F_RCLATCH] || ctrl_reg[`F_SHARE];
  wire [W-1:0] sinkMag = ioutCode[W-1] ? (~ioutCode + 1'b1) : {W{1'b0}};
  wire ocNow = !ioutCode[W-1] && ioutCode > $signed({1'b0, ocLimit_reg[W-2:0]});
  wire rcNow = sinkMag > rcLimit_reg;
  wire ocTrip = state_reg == S_ON && ocCnt_reg == `FILT_CYC - 1 && ocNow;
  wire rcTrip = state_reg == S_ON && rcCnt_reg == `FILT_CYC - 1 && rcNow;
  wire [W-1:0] trkClamp = trackingInputPin < vTarget_reg ? trackingInputPin : vTarget_reg;

  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0;
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 6'h0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= !s_axi_awready && !awHeld_reg && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready <= !s_axi_wready && !wHeld_reg && !s_axi_bvalid && s_axi_wvalid;
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (mapped(wrAddr) && s_axi_awaddr[31:6] == 26'h0) || awHeld_reg
          ? (mapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR) : `RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld_reg <= 1'b1;
          awAddr_reg <= s_axi_awaddr[31:6] == 26'h0 ? s_axi_awaddr[5:0] : 6'h3F;
        end
        if (wTake) begin
          wHeld_reg <= 1'b1;
          wData_reg <= s_axi_wdata;
          wStrb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr[5:0]) && s_axi_araddr[31:6] == 26'h0
          ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr[5:0])
          `A_CTRL: s_axi_rdata <= {22'h0, ctrl_reg};
          `A_VTGT: s_axi_rdata <= {16'h0, vTarget_reg};
          `A_PGON: s_axi_rdata <= {16'h0, pgOn_reg};
          `A_UVLIM: s_axi_rdata <= {16'h0, uvLimit_reg};
          `A_PGDLY: s_axi_rdata <= {16'h0, pgDelay_reg};
          `A_TONDLY: s_axi_rdata <= {16'h0, tonDelay_reg};
          `A_TONRISE: s_axi_rdata <= {16'h0, tonRise_reg};
          `A_TOFFDLY: s_axi_rdata <= {16'h0, toffDelay_reg};
          `A_TOFFFALL: s_axi_rdata <= {16'h0, toffFall_reg};
          `A_OCLIM: s_axi_rdata <= {16'h0, ocLimit_reg};
          `A_RCLIM: s_axi_rdata <= {16'h0, rcLimit_reg};
          `A_ILV: s_axi_rdata <= {24'h0, group_reg, order_reg};
          `A_PERIOD: s_axi_rdata <= {16'h0, period_reg};
          `A_STATUS: s_axi_rdata <= {20'h0, latched_reg, rcFlag_reg, ocFlag_reg,
            pg_reg, 1'b0, state_reg};
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // config registers; the clear bit is a write pulse and never stores
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= `RST_CTRL;
      vTarget_reg <= `RST_VTGT;
      pgOn_reg <= `RST_PGON;
      uvLimit_reg <= `RST_UVLIM;
      pgDelay_reg <= `RST_PGDLY;
      tonDelay_reg <= `RST_TONDLY;
      tonRise_reg <= `RST_TONRISE;
      toffDelay_reg <= `RST_TOFFDLY;
      toffFall_reg <= `RST_TOFFFALL;
      ocLimit_reg <= `RST_OCLIM;
      rcLimit_reg <= `RST_RCLIM;
      period_reg <= `RST_PERIOD;
      group_reg <= `RST_GROUP;
      order_reg <= 4'h0;
      orderLoaded_reg <= 1'b0;
    end else if (ce) begin
      if (!orderLoaded_reg) begin
        order_reg <= busAddress[3:0];
        orderLoaded_reg <= 1'b1;
      end
      if (doWrite) begin
        case (wrAddr)
          `A_CTRL: ctrl_reg <= {1'b0, ctrlNew[8:0]};
          `A_VTGT: vTarget_reg <= mergeBytes(vTarget_reg, wrData, wrStrb);
          `A_PGON: pgOn_reg <= mergeBytes(pgOn_reg, wrData, wrStrb);
          `A_UVLIM: uvLimit_reg <= mergeBytes(uvLimit_reg, wrData, wrStrb);
          `A_PGDLY: pgDelay_reg <= mergeBytes(pgDelay_reg, wrData, wrStrb);
          `A_TONDLY: tonDelay_reg <= mergeBytes(tonDelay_reg, wrData, wrStrb);
          `A_TONRISE: tonRise_reg <= mergeBytes(tonRise_reg, wrData, wrStrb);
          `A_TOFFDLY: toffDelay_reg <= mergeBytes(toffDelay_reg, wrData, wrStrb);
          `A_TOFFFALL: toffFall_reg <= mergeBytes(toffFall_reg, wrData, wrStrb);
          `A_OCLIM: ocLimit_reg <= mergeBytes(ocLimit_reg, wrData, wrStrb);
          `A_RCLIM: rcLimit_reg <= mergeBytes(rcLimit_reg, wrData, wrStrb);
          `A_PERIOD: period_reg <= mergeBytes(period_reg, wrData, wrStrb);
          `A_ILV: begin
            if (wrStrb[0]) begin
              order_reg <= wrData[3:0];
              group_reg <= wrData[7:4];
            end
          end
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // sequencer; ramps step the setpoint by bresenham, so a ramp can climb
  // at most one code per cycle: rise time must be at least the target code
  always @(posedge core_clk) begin
    if (srst) begin
      state_reg <= S_OFF;
      tmr_reg <= 32'h0;
      acc_reg <= {W{1'b0}};
      vSetpoint <= {W{1'b0}};
      regulateEn <= 1'b0;
      syncRectEn <= 1'b0;
      ocCnt_reg <= 4'h0;
      rcCnt_reg <= 4'h0;
      ocFlag_reg <= 1'b0;
      rcFlag_reg <= 1'b0;
      latched_reg <= 1'b0;
    end else if (ce) begin
      ocCnt_reg <= (state_reg == S_ON && ocNow) ? ocCnt_reg + 4'h1 : 4'h0;
      rcCnt_reg <= (state_reg == S_ON && rcNow) ? rcCnt_reg + 4'h1 : 4'h0;
      // hardware set wins over software clear
      ocFlag_reg <= ocTrip || (ocFlag_reg && !clearCmd);
      rcFlag_reg <= rcTrip || (rcFlag_reg && !clearCmd);
      tmr_reg <= tmr_reg + 32'h1;
      // drop with the leaving edge so rectifiers never outlast regulation
      syncRectEn <= state_reg == S_ON && enActive && !(ocTrip || rcTrip);
      case (state_reg)
        S_OFF: begin
          regulateEn <= 1'b0;
          vSetpoint <= {W{1'b0}};
          if (enActive) begin
            state_reg <= S_ONDLY;
            tmr_reg <= 32'h0;
          end
        end
        S_ONDLY: begin
          if (!enActive) begin
            state_reg <= S_OFF;
          end else if (trackMode || tmr_reg >= {16'h0, tonDelay_reg}) begin
            state_reg <= S_RISE;
            acc_reg <= {W{1'b0}};
            regulateEn <= 1'b1;
          end
        end
        S_RISE: begin
          if (!enActive) begin
            state_reg <= S_OFFDLY;
            tmr_reg <= 32'h0;
          end else if (trackMode) begin
            vSetpoint <= trkClamp;
            if (trackingInputPin >= vTarget_reg) begin
              state_reg <= S_ON;
            end
          end else if (vSetpoint >= vTarget_reg) begin
            state_reg <= S_ON;
          end else if (acc_reg + vTarget_reg >= tonRise_reg) begin
            acc_reg <= acc_reg + vTarget_reg - tonRise_reg;
            vSetpoint <= vSetpoint + 1'b1;
          end else begin
            acc_reg <= acc_reg + vTarget_reg;
          end
        end
        S_ON: begin
          vSetpoint <= vTarget_reg;
          if (ocTrip || rcTrip) begin
            state_reg <= S_FAULT;
            regulateEn <= 1'b0;
            vSetpoint <= {W{1'b0}};
            latched_reg <= ocTrip ? ocLatch : rcLatch;
            tmr_reg <= 32'h0;
          end else if (!enActive) begin
            tmr_reg <= 32'h0;
            acc_reg <= {W{1'b0}};
            if (ctrl_reg[`F_SOFTSTOP] || trackMode) begin
              state_reg <= S_OFFDLY;
            end else begin
              state_reg <= S_OFF;
              regulateEn <= 1'b0;
            end
          end
        end
        S_OFFDLY: begin
          if (trackMode || tmr_reg >= {16'h0, toffDelay_reg}) begin
            state_reg <= S_FALL;
          end
        end
        S_FALL: begin
          if (trackMode) begin
            vSetpoint <= trkClamp;
            if (trackingInputPin == {W{1'b0}}) begin
              state_reg <= S_OFF;
            end
          end else if (vSetpoint == {W{1'b0}}) begin
            state_reg <= S_OFF;
          end else if (acc_reg + vTarget_reg >= toffFall_reg) begin
            acc_reg <= acc_reg + vTarget_reg - toffFall_reg;
            vSetpoint <= vSetpoint - 1'b1;
          end else begin
            acc_reg <= acc_reg + vTarget_reg;
          end
        end
        S_FAULT: begin
          regulateEn <= 1'b0;
          vSetpoint <= {W{1'b0}};
          if (latched_reg) begin
            if (clearCmd || !enActive) begin
              state_reg <= S_OFF;
              latched_reg <= 1'b0;
            end
          end else if (tmr_reg >= HICCUP_CYCLES - 1) begin
            state_reg <= S_OFF;
          end
        end
        default: state_reg <= S_OFF;
      endcase
    end
  end

  // ready output
  always @(posedge core_clk) begin
    if (srst) begin
      pg_reg <= 1'b0;
      pgCnt_reg <= {W{1'b0}};
      outputReadyPinOut <= 1'b0;
      outputReadyPinOeN <= 1'b0;
    end else if (ce) begin
      if (state_reg != S_ON || ocTrip || rcTrip || voutCode < uvLimit_reg) begin
        pg_reg <= 1'b0;
        pgCnt_reg <= {W{1'b0}};
      end else if (!pg_reg && voutCode >= pgOn_reg) begin
        if (pgCnt_reg >= pgDelay_reg) begin
          pg_reg <= 1'b1;
        end else begin
          pgCnt_reg <= pgCnt_reg + 1'b1;
        end
      end
      outputReadyPinOut <= pg_reg;
      // open drain releases the pin when ready; push-pull always drives
      outputReadyPinOeN <= pg_reg && !ctrl_reg[`F_PUSHPULL];
    end
  end

  // phase counter: two pwm edges half a period apart per period
  wire [W-1:0] halfPeriod = {1'b0, period_reg[W-1:1]};
  wire [4:0] groupSize = group_reg == 4'h0 ? 5'h10 : {1'b0, group_reg};
  wire [W+3:0] prod = period_reg * order_reg;
  wire [W+3:0] offFull = prod / groupSize;
  wire syncRise = syncRole == `SYNC_INPUT && syncPinIn && !syncPrev_reg;
  wire [W-1:0] offB = offset_reg >= halfPeriod ? offset_reg - halfPeriod
    : offset_reg + halfPeriod;
  always @(posedge core_clk) begin
    if (srst) begin
      phCnt_reg <= {W{1'b0}};
      syncPrev_reg <= 1'b0;
      offset_reg <= {W{1'b0}};
      syncPinOut <= 1'b0;
      syncPinOeN <= 1'b1;
      pwmEdgeA <= 1'b0;
      pwmEdgeB <= 1'b0;
    end else if (ce) begin
      syncPrev_reg <= syncPinIn;
      offset_reg <= offFull[W-1:0];
      if (syncRise || phCnt_reg >= period_reg - 1'b1) begin
        phCnt_reg <= {W{1'b0}};
      end else begin
        phCnt_reg <= phCnt_reg + 1'b1;
      end
      syncPinOeN <= syncRole != `SYNC_OUTPUT;
      syncPinOut <= syncRole == `SYNC_OUTPUT && phCnt_reg < halfPeriod;
      pwmEdgeA <= regulateEn && phCnt_reg == offset_reg;
      pwmEdgeB <= regulateEn && phCnt_reg == offB;
    end
  end
endmodule
`default_nettype wire

// [hdl/pol_seq_regs.vh]
// register map, field positions, reset values and timing counts of the sequencer
// assumes a 32-bit AXI4-Lite register bus and a 20 MHz core clock
`ifndef POL_SEQ_REGS_VH
`define POL_SEQ_REGS_VH
`define CLK_HZ 20000000
`define A_CTRL 6'h00
`define A_VTGT 6'h04
`define A_PGON 6'h08
`define A_UVLIM 6'h0C
`define A_PGDLY 6'h10
`define A_TONDLY 6'h14
`define A_TONRISE 6'h18
`define A_TOFFDLY 6'h1C
`define A_TOFFFALL 6'h20
`define A_OCLIM 6'h24
`define A_RCLIM 6'h28
`define A_ILV 6'h2C
`define A_PERIOD 6'h30
`define A_STATUS 6'h34
`define F_ENPOL 0
`define F_SOFTSTOP 1
`define F_TRACK 2
`define F_SHARE 3
`define F_PUSHPULL 4
`define F_SYNCLO 5
`define F_SYNCHI 6
`define F_OCLATCH 7
`define F_RCLATCH 8
`define F_CLRFLT 9
`define SYNC_INTERNAL 2'h0
`define SYNC_INPUT 2'h1
`define SYNC_OUTPUT 2'h2
`define RST_CTRL 10'h001
`define RST_VTGT 16'h03E8
`define RST_PGON 16'h0384
`define RST_UVLIM 16'h0352
`define RST_PGDLY 16'h0014
`define RST_TONDLY 16'h0064
`define RST_TONRISE 16'h03E8
`define RST_TOFFDLY 16'h0064
`define RST_TOFFFALL 16'h03E8
`define RST_OCLIM 16'h7000
`define RST_RCLIM 16'h1000
`define RST_GROUP 4'h0
`define RST_PERIOD 16'h0028
`define HICCUP_US 20000
`define HICCUP_CYC ((`HICCUP_US * (`CLK_HZ / 1000000)))
`define FILT_CYC 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [testbench/pol_seq_asserts.sv]
// concurrent checks on the sequencer ports, attached by bind
// assumes default ready thresholds, current limits and phase period
`default_nettype none
module pol_seq_asserts #(
  parameter W = 16,
  parameter HICCUP_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [W-1:0] voutCode,
  input wire logic signed [W-1:0] ioutCode,
  input wire logic outputReadyPinOut,
  input wire logic outputReadyPinOeN,
  input wire logic regulateEn,
  input wire logic syncRectEn,
  input wire logic syncPinOeN,
  input wire logic pwmEdgeA,
  input wire logic pwmEdgeB
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [W-1:0] READY_ON = 16'h0384;
  localparam logic [W-1:0] UV_LIM = 16'h0352;
  localparam logic signed [W-1:0] OC_LIM = 16'sh7000;
  localparam logic signed [W-1:0] RC_LIM = -16'sh1000;
  // a released open-drain pin reads high through the pull-up
  wire logic readyLvl = outputReadyPinOeN | outputReadyPinOut;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_reset_quiet: assert property ($fell(srst) |-> !regulateEn && !syncRectEn && syncPinOeN && !readyLvl)
    else $error("outputs not idle after reset");
  a_ramp_dark: assert property ((regulateEn && !syncRectEn)[*3] |-> !readyLvl)
    else $error("ready high while ramping");
  a_off_dark: assert property ((!regulateEn)[*3] |-> !readyLvl)
    else $error("ready high while off");
  a_ready_late: assert property ($rose(readyLvl) |-> $past(syncRectEn, 20) && $past(voutCode, 21) >= READY_ON)
    else $error("ready rose too early");
  a_uv_drop: assert property (readyLvl && voutCode < UV_LIM |-> ##[1:3] !readyLvl)
    else $error("ready kept below limit");
  a_oc_trip: assert property ((syncRectEn && ioutCode > OC_LIM)[*8] |-> ##[0:3] !regulateEn)
    else $error("overload not shut down");
  a_rev_trip: assert property ((syncRectEn && ioutCode < RC_LIM)[*8] |-> ##[0:3] !regulateEn)
    else $error("reverse current not shut down");
  a_rect_on: assert property (syncRectEn |-> regulateEn)
    else $error("rectifiers on without regulation");
  a_drive_kind: assert property (outputReadyPinOeN |-> outputReadyPinOut)
    else $error("ready released while not ready");
  a_half_period: assert property (pwmEdgeA ##20 regulateEn |-> pwmEdgeB)
    else $error("second phase not at half period");
  cover property ($rose(readyLvl));
  cover property ($fell(regulateEn) && $past(syncRectEn));
  cover property (pwmEdgeB && regulateEn);
endmodule
bind pol_seq pol_seq_asserts #(.W(W), .HICCUP_CYCLES(HICCUP_CYCLES)) chk0 (
  .core_clk(core_clk), .srst(srst), .voutCode(voutCode), .ioutCode(ioutCode),
  .outputReadyPinOut(outputReadyPinOut), .outputReadyPinOeN(outputReadyPinOeN),
  .regulateEn(regulateEn), .syncRectEn(syncRectEn), .syncPinOeN(syncPinOeN),
  .pwmEdgeA(pwmEdgeA), .pwmEdgeB(pwmEdgeB));
`default_nettype wire

// [testbench/pol_plant.sv]
// output stage stand-in: voltage follows the reference while regulating
// assumes the sequencer's registered outputs on core_clk
`default_nettype none
module pol_plant (
  input wire logic core_clk,
  input wire logic regulateEn,
  input wire logic syncRectEn,
  input wire logic [15:0] vSetpoint,
  input wire logic signed [15:0] loadCode,
  input wire logic sag,
  output var logic [15:0] voutCode,
  output var logic signed [15:0] ioutCode
);
  timeunit 1ns;
  timeprecision 1ps;
  initial voutCode = 16'h0000;
  // a pre-biased output bleeds down slowly, it never snaps to zero
  always @(posedge core_clk) begin
    if (sag)
      voutCode <= 16'h0300;
    else if (regulateEn)
      voutCode <= vSetpoint;
    else if (voutCode > 16'h0007)
      voutCode <= voutCode - 16'h0008;
  end
  // sinking needs the rectifiers, so no reverse current before they are on
  always @* begin
    ioutCode = regulateEn ? loadCode : 16'sh0000;
    if (!syncRectEn && ioutCode < 0)
      ioutCode = 16'sh0000;
  end
endmodule
`default_nettype wire

// [testbench/tb_pol_seq.sv]
// self-checking bench: AXI4-Lite host tasks, plant model, bound checker
// assumes default register values and a shortened hiccup interval
`include "pol_seq_regs.vh"
`default_nettype none
module tb_pol_seq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HIC = 50;
  logic core_clk = 1'b0, srst = 1'b1, enablePin = 1'b0, sag = 1'b0, ce = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [6:0] busAddress = 7'h0;
  logic [15:0] track = 16'h0, big;
  logic signed [15:0] load = 16'sh0;
  logic [33:0] expQ[$], e;
  wire logic awready, wready, bvalid, arready, rvalid, regulateEn, syncRectEn, syncPinOeN;
  wire logic readyOut, readyOeN, syncOut, edgeA;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] vout, vSetpoint;
  wire logic signed [15:0] iout;
  int mismatches = 0, checked = 0, n;
  pol_seq #(.W(16), .HICCUP_CYCLES(HIC)) uut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .enablePin(enablePin), .busAddress(busAddress), .voutCode(vout), .ioutCode(iout),
    .trackingInputPin(track), .syncPinIn(1'b0), .syncPinOut(syncOut), .syncPinOeN(syncPinOeN),
    .outputReadyPinOut(readyOut), .outputReadyPinOeN(readyOeN), .regulateEn(regulateEn),
    .syncRectEn(syncRectEn), .vSetpoint(vSetpoint), .pwmEdgeA(edgeA), .pwmEdgeB());
  pol_plant plant (.core_clk(core_clk), .regulateEn(regulateEn), .syncRectEn(syncRectEn),
    .vSetpoint(vSetpoint), .loadCode(load), .sag(sag), .voutCode(vout), .ioutCode(iout));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo;
    mismatches++;
    $display("FAIL %0t wait ran out", $time);
    print_verdict();
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = regulateEn;
      1: pick = syncRectEn;
      3: pick = syncOut;
      4: pick = edgeA;
      default: pick = readyOeN | readyOut;
    endcase
  endfunction
  task automatic waitSig(input int k, input logic v, input int lim, output int c);
    c = 0;
    while (pick(k) !== v) begin
      @(posedge core_clk);
      if (++c > lim) tmo();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge core_clk);
    awaddr <= {26'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (++c > 200) tmo();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, `RESP_OKAY});
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int c;
    c = 0;
    expQ.push_back({er, d});
    @(posedge core_clk);
    araddr <= {26'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (++c > 200) tmo();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // read results are matched in order against the notes left by rd
  always @(posedge core_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 34'h3_FFFF_FFFF;
      chk(rdata, e[31:0]);
      chk({30'h0, rresp}, {30'h0, e[33:32]});
    end
  end
  initial begin
    n = $urandom(32'h3d562513);
    busAddress = 7'($urandom);
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd(`A_CTRL, 32'h1, `RESP_OKAY);
    rd(`A_STATUS, 32'h1, `RESP_OKAY);
    rd(`A_ILV, {28'h0, busAddress[3:0]}, `RESP_OKAY);
    rd(6'h38, 32'h0, `RESP_SLVERR);
    wr(`A_ILV, 32'hFFFF_FF53);
    rd(`A_ILV, 32'h53, `RESP_OKAY);
    enablePin <= 1'b1;
    repeat (50) @(posedge core_clk);
    chk(regulateEn, 1'b0);
    // a frozen clock enable must hold the on delay where it is
    ce <= 1'b0;
    repeat (100) @(posedge core_clk);
    ce <= 1'b1;
    chk(regulateEn, 1'b0);
    waitSig(0, 1'b1, 200, n);
    for (int k = 0; k < 2; k++) begin
      big = k ? 16'hE000 - 16'($urandom % 4096) : 16'h7001 + 16'($urandom % 2047);
      load <= big;
      waitSig(1, 1'b1, 3000, n);
      waitSig(0, 1'b0, 12, n);
      rd(`A_STATUS, k ? 32'h440 : 32'h240, `RESP_OKAY);
      waitSig(0, 1'b1, 400, n);
      chk(n > HIC + 80, 1'b1);
      load <= 16'sh0;
      wr(`A_CTRL, 32'h201);
    end
    for (int k = 0; k < 2; k++) begin
      waitSig(1, 1'b1, 3000, n);
      wr(`A_CTRL, k ? 32'h009 : 32'h181);
      load <= 16'sh7800;
      waitSig(0, 1'b0, 12, n);
      load <= 16'sh0;
      repeat (HIC + 200) @(posedge core_clk);
      chk(regulateEn, 1'b0);
      rd(`A_STATUS, 32'hA40, `RESP_OKAY);
      if (k) begin
        enablePin <= 1'b0;
        repeat (3) @(posedge core_clk);
        enablePin <= 1'b1;
      end else
        wr(`A_CTRL, 32'h381);
      waitSig(0, 1'b1, 200, n);
    end
    wr(`A_CTRL, 32'h201);
    waitSig(1, 1'b1, 3000, n);
    enablePin <= 1'b0;
    waitSig(0, 1'b0, 4, n);
    wr(`A_CTRL, 32'h003);
    enablePin <= 1'b1;
    waitSig(1, 1'b1, 3000, n);
    enablePin <= 1'b0;
    waitSig(1, 1'b0, 4, n);
    rd(`A_STATUS, 32'h010, `RESP_OKAY);
    waitSig(0, 1'b0, 3000, n);
    chk(n > 1000, 1'b1);
    chk(vSetpoint, 32'h0);
    wr(`A_CTRL, 32'h010); // low enable level is now active
    waitSig(2, 1'b1, 3000, n);
    chk(readyOeN, 1'b0);
    sag <= 1'b1;
    waitSig(2, 1'b0, 5, n);
    sag <= 1'b0;
    enablePin <= 1'b1;
    waitSig(0, 1'b0, 4, n);
    track <= 16'h0100;
    wr(`A_CTRL, 32'h005);
    waitSig(0, 1'b1, 6, n);
    repeat (20) @(posedge core_clk);
    chk(vSetpoint, 32'h0100);
    track <= 16'h2000;
    waitSig(1, 1'b1, 1000, n);
    chk(vSetpoint, 32'h03E8);
    wr(`A_CTRL, 32'h041);
    repeat (2) @(posedge core_clk);
    chk(syncPinOeN, 1'b0);
    waitSig(3, 1'b0, 45, n);
    waitSig(3, 1'b1, 45, n);
    waitSig(4, 1'b1, 45, n);
    chk(n, `RST_PERIOD * 16'h0003 / 16'h0005);
    chk(readyOeN, 1'b1);
    wr(`A_CTRL, 32'h021);
    repeat (2) @(posedge core_clk);
    chk(syncPinOeN, 1'b1);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(`A_CTRL, 32'h1, `RESP_OKAY);
    rd(`A_ILV, {28'h0, busAddress[3:0]}, `RESP_OKAY);
    repeat (3) @(posedge core_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
